// ==== supervisor_reset_watchdog.sv ====
// Supervisory reset generator, watchdog, chip-enable gate and status outputs
`timescale 1ns/1ps
module supervisor_reset_watchdog
	import supervisor_pkg::*;
#(
	parameter int unsigned RST_SHORT = RST_SHORT_CYC, // Short reset width, internal mode
	parameter int unsigned RST_LONG = RST_LONG_CYC, // Long reset width, internal mode
	parameter int unsigned WD_FAST = WD_FAST_CYC, // Fast watchdog period, internal mode
	parameter int unsigned WD_SLOW = WD_SLOW_CYC, // Slow watchdog period, internal mode
	parameter int unsigned EXT_RST = 64, // Reset width in external timing ticks
	parameter int unsigned EXT_WD = 256, // Watchdog period in external ticks
	parameter int unsigned EXT_WD_LONG = 4096, // First period after reset, external ticks
	parameter bit LONG_VARIANT = 1'b0 // Reset value of the long-width control bit
)
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic vcc_above_thr_i,
	input wire logic vcc_below_batt_i,
	input wire logic pf_sense_low_i,
	input wire logic watchdog_strobe_in_i,
	input wire logic strobe_mid_i,
	input wire logic timing_source_select_i,
	input wire logic timing_source_in_i,
	input wire logic ce_in_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic reset_n_o,
	output logic reset_o,
	output logic watchdog_expired_n_o,
	output logic power_fail_flag_n_o,
	output logic backup_active_o,
	output logic low_line_n_o,
	output logic ce_out_n_o
);

	//////////////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks on the parameters
	if (RST_SHORT < 8 || RST_LONG < 8 || EXT_RST < 8)
	begin : g_chk_rst
		$error("Reset widths must be at least 8 ticks");
	end
	if (WD_FAST < 2 || WD_SLOW >= (1 << CNT_W) || RST_LONG >= (1 << CNT_W)
		|| EXT_WD < 2 || EXT_WD_LONG >= (1 << CNT_W) || EXT_WD_LONG < EXT_WD)
	begin : g_chk_wd
		$error("Watchdog or reset period outside the timer range");
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [NSYNC-1:0] sync_a_ff; // First synchroniser stage, read only by the second
	logic [NSYNC-1:0] sync_b_ff; // Second synchroniser stage
	logic strobe_prev_ff; // Strobe level one cycle earlier
	logic src_prev_ff; // Timing input level one cycle earlier
	logic [CNT_W-1:0] rst_cnt_ff; // Remaining reset hold ticks
	logic [CNT_W-1:0] nxt_rst_cnt;
	logic [CNT_W-1:0] wd_cnt_ff; // Watchdog ticks since last service
	logic [CNT_W-1:0] nxt_wd_cnt;
	logic first_long_ff; // Next watchdog period is the long one
	logic nxt_first_long;
	logic long_rst_ff; // Control bit: long reset width
	logic nxt_long_rst;
	logic wait_ff; // Bus wait state
	logic nxt_wait;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic nxt_reset_n;
	logic nxt_wdo_n;
	// Synchronised pin levels
	wire vcc_ok_s = sync_b_ff[SI_VCC_OK];
	wire below_batt_s = sync_b_ff[SI_BELOW_BATT];
	wire pf_low_s = sync_b_ff[SI_PF_LOW];
	wire strobe_s = sync_b_ff[SI_STROBE];
	wire mid_s = sync_b_ff[SI_STROBE_MID];
	wire src_sel_s = sync_b_ff[SI_SRC_SEL];
	wire src_in_s = sync_b_ff[SI_SRC_IN];
	wire ce_n_s = sync_b_ff[SI_CE_N];

	//////////////////////////////////////////////////////////////////////////////////////////
	// Period selection
	// Picks a period for internal or external timing and truncates to the timer width
	function automatic logic [CNT_W-1:0] pick(input logic ext, input int unsigned in_cyc,
		input int unsigned ext_ticks);
		pick = ext ? CNT_W'(ext_ticks) : CNT_W'(in_cyc);
	endfunction

	// Select low enables the external timing input, high or floating the internal clock
	wire ext_mode = !src_sel_s;
	// One timing tick: every system cycle, or each rising edge of the external source
	wire tick = ext_mode ? (src_in_s && !src_prev_ff) : 1'b1;
	// Reset hold width, chosen by the variant control bit in internal mode; EXT_RST in external mode
	wire [CNT_W-1:0] rst_period = pick(ext_mode, long_rst_ff ? RST_LONG : RST_SHORT, EXT_RST);
	// Internal mode: timing input high picks the slow period, low the fast one
	wire [CNT_W-1:0] wd_normal = pick(ext_mode, src_in_s ? WD_SLOW : WD_FAST, EXT_WD);
	// The first period after any reset is always the long one
	wire [CNT_W-1:0] wd_limit = first_long_ff ? pick(ext_mode, WD_SLOW, EXT_WD_LONG)
		: wd_normal;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Event decoding
	// Supply fault: below threshold or below the backup cell
	wire supply_fault = !vcc_ok_s || below_batt_s;
	// Any change of the strobe level, rising or falling
	wire strobe_edge = strobe_s ^ strobe_prev_ff;
	// Reset output is released and no fault is present
	wire sys_running = (rst_cnt_ff == '0) && !supply_fault;
	// Watchdog runs only with a two-level strobe and the system out of reset
	wire wd_run = !mid_s && sys_running;
	// Strobe static for the whole period; a strobe edge always takes precedence
	wire wd_expire = wd_run && !strobe_edge && (wd_cnt_ff >= wd_limit);

	//////////////////////////////////////////////////////////////////////////////////////////
	// Bus decoding
	wire bus_req = avs_read_i || avs_write_i;
	wire hit_ctrl = (avs_address_i == ADDR_CTRL);
	wire hit_status = (avs_address_i == ADDR_STATUS);
	// A write takes effect on the edge where wait is seen low
	wire wr_ctrl = avs_write_i && !wait_ff && hit_ctrl;
	wire [31:0] status_word = {24'h000000, first_long_ff, ext_mode, wd_run, backup_active_o,
		power_fail_flag_n_o, low_line_n_o, watchdog_expired_n_o, !reset_n_o};
	wire [31:0] ctrl_word = {31'h00000000, long_rst_ff};

	//////////////////////////////////////////////////////////////////////////////////////////
	// Next-state logic of the reset hold timer
	always_comb
	begin
		nxt_rst_cnt = rst_cnt_ff;
		if (supply_fault || wd_expire)
		begin
			// Any cause reloads the full hold width
			nxt_rst_cnt = rst_period;
		end
		else if (tick && rst_cnt_ff != '0)
		begin
			// Count down the hold once the cause is gone
			nxt_rst_cnt = rst_cnt_ff - CNT_W'(1);
		end
		// Reset stays asserted while a fault or the hold remains
		nxt_reset_n = !supply_fault && !wd_expire && (nxt_rst_cnt == '0);
	end

	// Next-state logic of the watchdog timer
	always_comb
	begin
		nxt_wd_cnt = wd_cnt_ff;
		nxt_first_long = first_long_ff;
		if (!wd_run || strobe_edge)
		begin
			// Disabled, in reset, or serviced: start again from zero
			nxt_wd_cnt = '0;
		end
		else if (tick && wd_cnt_ff < wd_limit)
		begin
			// Count towards the period, saturating at the limit
			nxt_wd_cnt = wd_cnt_ff + CNT_W'(1);
		end
		if (!sys_running)
		begin
			// Any reset arms the long first period
			nxt_first_long = 1'b1;
		end
		else if (wd_run && strobe_edge)
		begin
			// First service ends the long period
			nxt_first_long = 1'b0;
		end
	end

	// Next state of the watchdog-expired output
	always_comb
	begin
		nxt_wdo_n = watchdog_expired_n_o;
		if (!vcc_ok_s)
		begin
			// Supply-low status forces it high
			nxt_wdo_n = 1'b1;
		end
		else if (mid_s)
		begin
			// Disabled watchdog keeps it high
			nxt_wdo_n = 1'b1;
		end
		else if (strobe_edge)
		begin
			// Next strobe transition releases it
			nxt_wdo_n = 1'b1;
		end
		else if (wd_expire)
		begin
			// Missed service drives it low
			nxt_wdo_n = 1'b0;
		end
	end

	// Next state of the bus slave: one wait cycle, then the answer
	always_comb
	begin
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		nxt_long_rst = long_rst_ff;
		if (bus_req && wait_ff)
		begin
			// Request seen: drop wait and present read data next cycle
			nxt_wait = 1'b0;
			nxt_rdata = hit_ctrl ? ctrl_word : (hit_status ? status_word : 32'h00000000);
		end
		if (wr_ctrl)
		begin
			nxt_long_rst = avs_writedata_i[CTRL_LONG_RST];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers on all pin inputs
	always_ff @(posedge clk_sys_i)
	begin
		sync_a_ff <= {ce_in_n_i, timing_source_in_i, timing_source_select_i, strobe_mid_i,
			watchdog_strobe_in_i, pf_sense_low_i, vcc_below_batt_i, vcc_above_thr_i};
		sync_b_ff <= sync_a_ff;
	end

	// Timers and control state
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			strobe_prev_ff <= 1'b0;
			src_prev_ff <= 1'b0;
			rst_cnt_ff <= '0;
			wd_cnt_ff <= '0;
			first_long_ff <= 1'b1;
			long_rst_ff <= LONG_VARIANT;
		end
		else
		begin
			strobe_prev_ff <= strobe_s;
			src_prev_ff <= src_in_s;
			rst_cnt_ff <= nxt_rst_cnt;
			wd_cnt_ff <= nxt_wd_cnt;
			first_long_ff <= nxt_first_long;
			long_rst_ff <= nxt_long_rst;
		end
	end

	// Registered pin outputs
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			reset_n_o <= 1'b0;
			reset_o <= 1'b1;
			watchdog_expired_n_o <= 1'b1;
			power_fail_flag_n_o <= 1'b0;
			backup_active_o <= 1'b0;
			low_line_n_o <= 1'b0;
			ce_out_n_o <= 1'b1;
		end
		else
		begin
			reset_n_o <= nxt_reset_n;
			reset_o <= !nxt_reset_n;
			watchdog_expired_n_o <= nxt_wdo_n;
			power_fail_flag_n_o <= !(pf_low_s || below_batt_s);
			backup_active_o <= below_batt_s;
			low_line_n_o <= vcc_ok_s;
			ce_out_n_o <= !vcc_ok_s || ce_n_s;
		end
	end

	// Bus slave registers
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_waitrequest_o = wait_ff;
	assign avs_readdata_o = rdata_ff;
	//////////////////////////////////////////////////////////////////////////////////////////
	// Assertions
	// Supply returning good
	sequence s_supply_back;
		$fell(supply_fault);
	endsequence
	// Watchdog expiry followed by reset assertion
	sequence s_wd_fire;
		wd_expire ##1 !reset_n_o;
	endsequence
	property p_hold_after_supply;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_supply_back |-> !reset_n_o [*8];
	endproperty
	a_hold_after_supply: assert property (p_hold_after_supply)
		else $error("Reset released too soon after supply recovery");
	property p_wd_pulse;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_wd_fire |-> !reset_n_o [*7] ##1 (!watchdog_expired_n_o || !low_line_n_o);
	endproperty
	a_wd_pulse: assert property (p_wd_pulse)
		else $error("Watchdog reset pulse too short");
	property p_restart;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		strobe_edge |=> (wd_cnt_ff == '0);
	endproperty
	a_restart: assert property (p_restart)
		else $error("Strobe edge did not restart the watchdog");
	property p_mid_disable;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		mid_s |=> watchdog_expired_n_o && (wd_cnt_ff == '0);
	endproperty
	a_mid_disable: assert property (p_mid_disable)
		else $error("Watchdog active with mid-level strobe");
	property p_expire_low;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		wd_expire && vcc_ok_s |=> !watchdog_expired_n_o;
	endproperty
	a_expire_low: assert property (p_expire_low)
		else $error("Expired output not driven low on timeout");
	property p_edge_release;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		strobe_edge |=> watchdog_expired_n_o;
	endproperty
	a_edge_release: assert property (p_edge_release)
		else $error("Expired output not released by strobe edge");
	property p_lowline_wdo;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		!low_line_n_o |-> watchdog_expired_n_o && !reset_n_o;
	endproperty
	a_lowline_wdo: assert property (p_lowline_wdo)
		else $error("Supply low without forced outputs");
	property p_pfo;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		$past(pf_low_s) || backup_active_o |-> !power_fail_flag_n_o;
	endproperty
	a_pfo: assert property (p_pfo)
		else $error("Power-fail flag not low");
	property p_ce_gate;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		ce_out_n_o == (!low_line_n_o || $past(ce_n_s));
	endproperty
	a_ce_gate: assert property (p_ce_gate)
		else $error("Chip enable gating wrong");
	property p_inverse;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		reset_o != reset_n_o;
	endproperty
	a_inverse: assert property (p_inverse)
		else $error("Active-high reset not inverse of active-low");
	property p_first_long;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(reset_n_o) |-> first_long_ff;
	endproperty
	a_first_long: assert property (p_first_long)
		else $error("Long first period not armed after reset");
endmodule

// ==== supervisor_pkg.sv ====
// Constants, timing figures and register map of the supervisory watchdog block
//////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////
package supervisor_pkg;
	// System clock rate and derived cycles per millisecond
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// Documented times in milliseconds
	localparam int unsigned RST_SHORT_MS = 50;
	localparam int unsigned RST_LONG_MS = 200;
	localparam int unsigned WD_FAST_MS = 100;
	localparam int unsigned WD_SLOW_MS = 1600;
	// Same times as system clock cycles
	localparam int unsigned RST_SHORT_CYC = RST_SHORT_MS * CYC_PER_MS;
	localparam int unsigned RST_LONG_CYC = RST_LONG_MS * CYC_PER_MS;
	localparam int unsigned WD_FAST_CYC = WD_FAST_MS * CYC_PER_MS;
	localparam int unsigned WD_SLOW_CYC = WD_SLOW_MS * CYC_PER_MS;
	// Timer width, large enough for the slow watchdog period
	localparam int unsigned CNT_W = 24;
	// Positions of the pin inputs in the synchroniser vector
	localparam int unsigned NSYNC = 8;
	localparam int unsigned SI_VCC_OK = 0;
	localparam int unsigned SI_BELOW_BATT = 1;
	localparam int unsigned SI_PF_LOW = 2;
	localparam int unsigned SI_STROBE = 3;
	localparam int unsigned SI_STROBE_MID = 4;
	localparam int unsigned SI_SRC_SEL = 5;
	localparam int unsigned SI_SRC_IN = 6;
	localparam int unsigned SI_CE_N = 7;
	// Avalon-MM register map, byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	// Control register fields
	localparam int unsigned CTRL_LONG_RST = 0;
	// Status register fields
	localparam int unsigned ST_RESET = 0;
	localparam int unsigned ST_WDO_N = 1;
	localparam int unsigned ST_LOWLINE_N = 2;
	localparam int unsigned ST_PFO_N = 3;
	localparam int unsigned ST_BACKUP = 4;
	localparam int unsigned ST_WD_EN = 5;
	localparam int unsigned ST_EXT_SRC = 6;
	localparam int unsigned ST_FIRST_LONG = 7;
endpackage

// ==== supervisor_host_model.sv ====
// Processor-side model: watchdog strobe toggler and external timing source
`timescale 1ns/1ps
module supervisor_host_model
(
	input wire logic clk_sys_i,
	input wire logic strobe_run_i,
	input wire logic ext_run_i,
	input wire logic slow_sel_i,
	output logic watchdog_strobe_in_o,
	output logic timing_source_in_o
);
	logic [3:0] strobe_cnt_ff = 4'h0; // Cycles since last strobe edge
	logic strobe_ff = 1'b0; // Strobe level
	logic [3:0] tick_cnt_ff = 4'h0; // Half-period counter of the timing clock
	logic tick_ff = 1'b0; // Timing clock level, frozen while not running
	//////////////////////////////////////////////////////////////////////////////
	// Strobe flips every ten cycles while servicing is on
	always @(posedge clk_sys_i)
	begin
		if (strobe_run_i)
		begin
			strobe_cnt_ff <= (strobe_cnt_ff == 4'h9) ? 4'h0 : strobe_cnt_ff + 4'h1;
			if (strobe_cnt_ff == 4'h9)
				strobe_ff <= ~strobe_ff;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	// External clock of 4 cycles period; internal mode gives a select level
	always @(posedge clk_sys_i)
	begin
		if (ext_run_i)
		begin
			tick_cnt_ff <= tick_cnt_ff + 4'h1;
			if (tick_cnt_ff[0] == 1'b1)
				tick_ff <= ~tick_ff;
		end
	end
	assign watchdog_strobe_in_o = strobe_ff;
	assign timing_source_in_o = ext_run_i ? tick_ff : slow_sel_i;
endmodule

// ==== testbench.sv ====
// Self-checking bench for the supervisory reset and watchdog block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
	import supervisor_pkg::*;
	logic clk_sys_i; // System clock
	logic rst_b_i; // Synchronous reset, active low
	logic vcc_above, below_batt, pf_low, strobe_mid, src_sel, ce_in_n; // Pin levels
	logic strobe_run, ext_run, slow_sel; // Host model controls
	logic strobe, src_in; // Host model outputs
	logic [3:0] addr; // Bus address
	logic rd, wr; // Bus strobes
	logic [31:0] wdata, rdata, got; // Bus data
	logic waitreq, rst_n, rst_h, wdo_n, pfo_n, backup, low_line_n, ce_out_n; // Outputs
	int fail_count = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	localparam int RN = 0, RH = 1, WD = 2, PF = 3, BK = 4, LL = 5, CE = 6; // Output picks
	//////////////////////////////////////////////////////////////////////////////
	supervisor_reset_watchdog #(.RST_SHORT(20), .RST_LONG(40), .WD_FAST(50), .WD_SLOW(100))
		supervisor_reset_watchdog_i (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .vcc_above_thr_i(vcc_above),
		.vcc_below_batt_i(below_batt), .pf_sense_low_i(pf_low),
		.watchdog_strobe_in_i(strobe), .strobe_mid_i(strobe_mid),
		.timing_source_select_i(src_sel), .timing_source_in_i(src_in), .ce_in_n_i(ce_in_n),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .reset_n_o(rst_n),
		.reset_o(rst_h), .watchdog_expired_n_o(wdo_n), .power_fail_flag_n_o(pfo_n),
		.backup_active_o(backup), .low_line_n_o(low_line_n), .ce_out_n_o(ce_out_n));
	supervisor_host_model supervisor_host_model_i (.clk_sys_i(clk_sys_i),
		.strobe_run_i(strobe_run), .ext_run_i(ext_run), .slow_sel_i(slow_sel),
		.watchdog_strobe_in_o(strobe), .timing_source_in_o(src_in));
	//////////////////////////////////////////////////////////////////////////////
	// Clock of 100 ns period
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// Current level of one output
	function automatic logic pick(input int s);
		case (s)
			RN: return rst_n;
			RH: return rst_h;
			WD: return wdo_n;
			PF: return pfo_n;
			BK: return backup;
			LL: return low_line_n;
			default: return ce_out_n;
		endcase
	endfunction
	// Wait for an output level and check the number of cycles taken
	task automatic wait_out(input int s, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (pick(s) !== v && n <= hi)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask
	// Check that an output keeps one level for a number of cycles
	task automatic hold(input int s, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n)
		begin
			@(posedge clk_sys_i);
			if (pick(s) !== v)
				bad = 1'b1;
		end
		`CHK(bad, 1'b0)
	endtask
	// One bus transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do
		begin
			@(posedge clk_sys_i);
		end
		while (waitreq !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	// Cycles and marker
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic end_test(input string name);
		$display("test %s done, %0d checks so far", name, samples_checked);
	endtask
	// Verdict and end of run
	task automatic final_report;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// Watchdog against hangs
	initial
	begin
		cyc(20000);
		fail_count++;
		final_report();
	end
	// Main sequence
	initial
	begin
		rst_b_i = 1'b0;
		{vcc_above, below_batt, pf_low, strobe_mid, src_sel, ce_in_n} = 6'b000011;
		vcc_above = 1'b1;
		{strobe_run, ext_run, slow_sel, rd, wr} = 5'b00100;
		addr = 4'h0;
		wdata = 32'h0;
		cyc(8);
		rst_b_i <= 1'b1;
		wait_out(RN, 1'b1, 0, 10);
		`CHK({rst_h, low_line_n, pfo_n, backup}, 4'b0110)
		ce_in_n <= 1'b0;
		cyc(5);
		`CHK(ce_out_n, 1'b0)
		ce_in_n <= 1'b1;
		cyc(5);
		`CHK(ce_out_n, 1'b1)
		end_test("power-up");
		wait_out(WD, 1'b0, 85, 110);
		wait_out(RN, 1'b0, 0, 3);
		`CHK(rst_h, 1'b1)
		wait_out(RN, 1'b1, 15, 30);
		strobe_run <= 1'b1;
		wait_out(WD, 1'b1, 1, 16);
		hold(RN, 1'b1, 300);
		`CHK(wdo_n, 1'b1)
		slow_sel <= 1'b0;
		strobe_run <= 1'b0;
		wait_out(WD, 1'b0, 38, 60);
		end_test("watchdog");
		vcc_above <= 1'b0;
		strobe_mid <= 1'b1;
		ce_in_n <= 1'b0;
		wait_out(LL, 1'b0, 1, 5);
		wait_out(WD, 1'b1, 0, 3);
		cyc(3);
		`CHK({rst_n, ce_out_n}, 2'b01)
		vcc_above <= 1'b1;
		wait_out(LL, 1'b1, 1, 5);
		wait_out(RN, 1'b1, 15, 26);
		`CHK(ce_out_n, 1'b0)
		hold(WD, 1'b1, 250);
		`CHK(rst_n, 1'b1)
		end_test("supply");
		pf_low <= 1'b1;
		wait_out(PF, 1'b0, 1, 5);
		pf_low <= 1'b0;
		wait_out(PF, 1'b1, 1, 5);
		below_batt <= 1'b1;
		wait_out(BK, 1'b1, 1, 5);
		cyc(2);
		`CHK({pfo_n, rst_n}, 2'b00)
		below_batt <= 1'b0;
		wait_out(BK, 1'b0, 1, 5);
		wait_out(RN, 1'b1, 15, 30);
		end_test("backup");
		bus(1'b0, ADDR_STATUS, 32'h0);
		`CHK(got[7:0], 8'h8E)
		bus(1'b1, 4'h8, 32'hFFFF_FFFF);
		bus(1'b0, 4'h8, 32'h0);
		`CHK(got, 32'h0)
		bus(1'b1, ADDR_CTRL, 32'h0000_0001);
		bus(1'b0, ADDR_CTRL, 32'h0);
		`CHK(got[0], 1'b1)
		vcc_above <= 1'b0;
		wait_out(LL, 1'b0, 1, 5);
		vcc_above <= 1'b1;
		wait_out(LL, 1'b1, 1, 5);
		wait_out(RN, 1'b1, 35, 46);
		bus(1'b1, ADDR_CTRL, 32'h0);
		end_test("registers");
		src_sel <= 1'b0;
		ext_run <= 1'b1;
		strobe_mid <= 1'b0;
		strobe_run <= 1'b1;
		hold(WD, 1'b1, 400);
		strobe_run <= 1'b0;
		wait_out(WD, 1'b0, 1000, 1050);
		wait_out(RN, 1'b0, 0, 3);
		wait_out(RN, 1'b1, 240, 270);
		end_test("external timing");
		final_report();
	end
endmodule
